// [rtl/fbh_pkg.sv]
/*
 * constants, states and operation codes of the flash bus host.
 * assumes a 200 MHz clock and one byte-wide flash on the pins.
 */
package fbh_pkg;

	// ********************************
	// pin widths and sector layout
	// ********************************
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int SECT_MSB = 18; // sector number sits in the top three bits
	localparam int SECT_LSB = 16;
	localparam int SECT_W = SECT_MSB - SECT_LSB + 1;

	// ********************************
	// timing, in ns and in clock cycles
	// ********************************
	localparam int T_CLK_NS = 5;
	localparam int T_CE_NS = 120; // slowest chip-select access time
	localparam int T_WP_NS = 50; // write strobe low time
	localparam int CE_CYC = (T_CE_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int WP_CYC = (T_WP_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int TMR_W = 8;

	// ********************************
	// autoselect read addresses (a1:a0, a6 low)
	// ********************************
	localparam logic [ADDR_W-1:0] AS_MAKER_ADDR = 19'h0_0000;
	localparam logic [ADDR_W-1:0] AS_PART_ADDR = 19'h0_0001;
	localparam logic [ADDR_W-1:0] AS_PROT_ADDR = 19'h0_0002;

	// ********************************
	// user operations and sequencer states
	// ********************************
	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_RESET,
		OP_IDREAD
	} fbh_op_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_SETUP,
		ST_RD_WAIT,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_RELEASE
	} fbh_state_e;

	// sector number of a byte address
	function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
		sector_of = a[SECT_MSB:SECT_LSB];
	endfunction : sector_of

endpackage : fbh_pkg

// [rtl/fbh_timer.sv]
/*
 * down counter that flags the end of a strobe interval.
 * assumes start is a one-cycle pulse and load is at least one.
 */
`timescale 1ns/10ps
module fbh_timer #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic [W-1:0] load,
	// status
	output logic done
);

	// ********************************
	// counter
	// ********************************
	logic [W-1:0] cnt_r;

	// the end-of-count pattern needs at least two bits
	if (W < 2) begin : g_w_chk
		$error("W must be at least 2");
	end

	// reload on start, else run down to zero and stop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (start) begin
			cnt_r <= load;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	// done in the last counted cycle, so the caller can act on the next edge
	assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1}) && !start;

endmodule : fbh_timer

// [rtl/fbh_host.sv]
/*
 * host-side sequencer driving a byte-wide flash through its chip select,
 * output gate, write strobe, address and data pins.
 * assumes the flash pins are synchronous to CLK and the user waits for
 * REQ_READY before presenting the next operation.
 */
`timescale 1ns/10ps
module fbh_host #(
	parameter int CE_CYCLES = fbh_pkg::CE_CYC,
	parameter int WP_CYCLES = fbh_pkg::WP_CYC,
	parameter logic [7:0] RESET_CMD = 8'h00
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// user request
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire fbh_pkg::fbh_op_e REQ_OP,
	input wire logic [fbh_pkg::ADDR_W-1:0] REQ_ADDR,
	input wire logic [fbh_pkg::DATA_W-1:0] REQ_WDATA,
	// user answer
	output logic RSP_VALID,
	output logic [fbh_pkg::DATA_W-1:0] RSP_RDATA,
	output logic [fbh_pkg::SECT_W-1:0] RSP_SECTOR,
	// flash control pins
	output logic CE_N,
	output logic OE_N,
	output logic WE_N,
	output logic ID_HV_EN,
	// flash address and data pins
	output logic [fbh_pkg::ADDR_W-1:0] ADDRESS_PINS,
	input wire logic [fbh_pkg::DATA_W-1:0] DATA_PINS_I,
	output logic [fbh_pkg::DATA_W-1:0] DATA_PINS_O,
	output logic DATA_PINS_OE
);

	// ********************************
	// parameter checks
	// ********************************
	if (CE_CYCLES < 1 || CE_CYCLES > 255) begin : g_ce_chk
		$error("CE_CYCLES must be 1 to 255");
	end
	if (WP_CYCLES < 1 || WP_CYCLES > 255) begin : g_wp_chk
		$error("WP_CYCLES must be 1 to 255");
	end

	// ********************************
	// state record
	// ********************************
	typedef struct packed {
		fbh_pkg::fbh_state_e st;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic hv;
		logic [fbh_pkg::ADDR_W-1:0] addr;
		logic [fbh_pkg::DATA_W-1:0] dout;
		logic dq_oe;
		logic rsp;
		logic [fbh_pkg::DATA_W-1:0] rdata;
		logic [fbh_pkg::SECT_W-1:0] sect;
	} fbh_state_s;

	fbh_state_s s_r;
	fbh_state_s s_nxt;
	logic tmr_start;
	logic [fbh_pkg::TMR_W-1:0] tmr_load;
	logic tmr_done;

	// one interval timer shared by the access wait and the strobe pulse
	fbh_timer #(
		.W(fbh_pkg::TMR_W)
	) u_timer (
		.clk(CLK),
		.rst_n(RESETN),
		.start(tmr_start),
		.load(tmr_load),
		.done(tmr_done)
	);

	// ********************************
	// sequencer
	// ********************************
	// strobe and gate changes are one state apart from address and data, so those
	// never move under a WE_N or OE_N edge
	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp = 1'b0;
		tmr_start = 1'b0;
		tmr_load = fbh_pkg::TMR_W'(CE_CYCLES);
		case (s_r.st)
			fbh_pkg::ST_IDLE: begin
				if (REQ_VALID) begin
					s_nxt.addr = REQ_ADDR; // address set in the same cycle that select falls
					s_nxt.sect = fbh_pkg::sector_of(REQ_ADDR);
					s_nxt.ce_n = 1'b0;
					case (REQ_OP)
						fbh_pkg::OP_READ: begin
							s_nxt.st = fbh_pkg::ST_RD_SETUP;
						end
						fbh_pkg::OP_IDREAD: begin
							s_nxt.hv = 1'b1; // a9 raised for identifier reads
							s_nxt.st = fbh_pkg::ST_RD_SETUP;
						end
						fbh_pkg::OP_RESET: begin
							s_nxt.dout = RESET_CMD; // exit from autoselect
							s_nxt.dq_oe = 1'b1;
							s_nxt.st = fbh_pkg::ST_WR_SETUP;
						end
						default: begin
							s_nxt.dout = REQ_WDATA;
							s_nxt.dq_oe = 1'b1; // gate stays high while we drive
							s_nxt.st = fbh_pkg::ST_WR_SETUP;
						end
					endcase
				end
			end
			fbh_pkg::ST_RD_SETUP: begin
				s_nxt.oe_n = 1'b0; // select and gate low, strobe high
				tmr_start = 1'b1;
				tmr_load = fbh_pkg::TMR_W'(CE_CYCLES);
				s_nxt.st = fbh_pkg::ST_RD_WAIT;
			end
			fbh_pkg::ST_RD_WAIT: begin
				if (tmr_done) begin
					s_nxt.rdata = DATA_PINS_I; // sampled only after access time
					s_nxt.rsp = 1'b1;
					s_nxt.oe_n = 1'b1;
					s_nxt.ce_n = 1'b1;
					s_nxt.st = fbh_pkg::ST_RELEASE;
				end
			end
			fbh_pkg::ST_WR_SETUP: begin
				s_nxt.we_n = 1'b0; // strobe falls with address already stable
				tmr_start = 1'b1;
				tmr_load = fbh_pkg::TMR_W'(WP_CYCLES);
				s_nxt.st = fbh_pkg::ST_WR_PULSE;
			end
			fbh_pkg::ST_WR_PULSE: begin
				if (tmr_done) begin
					s_nxt.we_n = 1'b1; // data latched by the flash on this rise
					s_nxt.st = fbh_pkg::ST_WR_HOLD;
				end
			end
			fbh_pkg::ST_WR_HOLD: begin
				// data and select held one cycle past the rising strobe
				s_nxt.dq_oe = 1'b0;
				s_nxt.ce_n = 1'b1;
				s_nxt.rsp = 1'b1;
				s_nxt.st = fbh_pkg::ST_RELEASE;
			end
			fbh_pkg::ST_RELEASE: begin
				// one idle cycle gives the flash time to float its outputs
				s_nxt.hv = 1'b0;
				s_nxt.st = fbh_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.st = fbh_pkg::ST_IDLE;
			end
		endcase
	end

	// register the record; select, gate and strobe idle high, data floating from reset
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_r <= '{st: fbh_pkg::ST_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				hv: 1'b0, addr: '0, dout: '0, dq_oe: 1'b0, rsp: 1'b0,
				rdata: '0, sect: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ********************************
	// outputs
	// ********************************
	assign REQ_READY = (s_r.st == fbh_pkg::ST_IDLE);
	assign RSP_VALID = s_r.rsp;
	assign RSP_RDATA = s_r.rdata;
	assign RSP_SECTOR = s_r.sect;
	assign CE_N = s_r.ce_n;
	assign OE_N = s_r.oe_n;
	assign WE_N = s_r.we_n;
	assign ID_HV_EN = s_r.hv;
	assign ADDRESS_PINS = s_r.addr;
	assign DATA_PINS_O = s_r.dout;
	assign DATA_PINS_OE = s_r.dq_oe;

	// ********************************
	// checks
	// ********************************
	logic [fbh_pkg::TMR_W-1:0] oe_run_r; // cycles the gate has been low

	// count the gate-low run, saturating
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			oe_run_r <= '0;
		end else if (OE_N) begin
			oe_run_r <= '0;
		end else if (oe_run_r != '1) begin
			oe_run_r <= oe_run_r + 1'b1;
		end
	end

	read_levels_a: assert property (@(posedge CLK) disable iff (!RESETN)
		!OE_N |-> !CE_N && WE_N && !DATA_PINS_OE)
		else $error("gate low without proper read levels");
	write_levels_a: assert property (@(posedge CLK) disable iff (!RESETN)
		!WE_N |-> !CE_N && OE_N && DATA_PINS_OE)
		else $error("strobe low without proper write levels");
	no_contention_a: assert property (@(posedge CLK) disable iff (!RESETN)
		DATA_PINS_OE |-> OE_N)
		else $error("host drives data while gate is low");
	access_wait_a: assert property (@(posedge CLK) disable iff (!RESETN)
		$rose(OE_N) && $past(!WE_N) == 1'b0 |-> oe_run_r >= CE_CYCLES && RSP_VALID)
		else $error("read data taken before access time");
	rsp_data_a: assert property (@(posedge CLK) disable iff (!RESETN)
		RSP_VALID && $past(!OE_N) |-> RSP_RDATA == $past(DATA_PINS_I))
		else $error("read answer differs from sampled pins");
	data_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
		$rose(WE_N) |-> DATA_PINS_OE && !CE_N && $stable(DATA_PINS_O))
		else $error("data not held at strobe rise");
	addr_stable_a: assert property (@(posedge CLK) disable iff (!RESETN)
		!CE_N && $past(!CE_N) |-> $stable(ADDRESS_PINS))
		else $error("address moved while selected");
	hv_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
		ID_HV_EN |-> WE_N && !DATA_PINS_OE)
		else $error("write attempted with a9 raised");
	reset_cmd_a: assert property (@(posedge CLK) disable iff (!RESETN)
		REQ_VALID && REQ_READY && REQ_OP == fbh_pkg::OP_RESET
		|=> DATA_PINS_O == RESET_CMD ##1 !WE_N)
		else $error("reset command not written");
	done_bound_a: assert property (@(posedge CLK) disable iff (!RESETN)
		!REQ_READY |-> ##[1:600] CE_N)
		else $error("select held low too long");

	read_seen_c: cover property (@(posedge CLK) disable iff (!RESETN)
		RSP_VALID && $past(!OE_N));
	write_seen_c: cover property (@(posedge CLK) disable iff (!RESETN)
		$rose(WE_N));
	idread_seen_c: cover property (@(posedge CLK) disable iff (!RESETN)
		ID_HV_EN && !OE_N);

endmodule : fbh_host

// [testbench/fbh_flash_model.sv]
/* behavioural byte-wide flash for the host bench.
 * assumes strobes come straight from the host pins. */
`timescale 1ns/10ps
module fbh_flash_model #(
	parameter int ACC_NS = 110,
	parameter logic [7:0] MAKER = 8'h5A, // arbitrary value
	parameter logic [7:0] PART = 8'h3C, // arbitrary value
	parameter logic [7:0] PROT = 8'h24,
	parameter logic [7:0] RST_CODE = 8'hF0,
	parameter logic [7:0] AS_CODE = 8'h90,
	parameter logic [7:0] ERASE_CODE = 8'h30, // arbitrary value
	parameter logic [7:0] CHIP_CODE = 8'h10, // arbitrary value
	parameter logic [7:0] STATUS = 8'h4C, // arbitrary busy status byte
	parameter int BUSY_NS = 300
) (
	// strobes
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic hv,
	// address and data
	input wire logic [18:0] addr,
	input wire logic [7:0] din,
	input wire logic din_oe,
	output logic [7:0] dq,
	output int clash
);
	// ****
	// state
	// ****
	logic [7:0] mem [logic [18:0]];
	logic [18:0] cap_a;
	logic [7:0] val;
	logic autosel = 1'b0; // array mode from power-up
	logic acc_ok = 1'b0;
	logic busy = 1'b0;
	realtime t_sel = 0.0;
	realtime busy_until = 0.0;
	wire drv = !ce_n && !oe_n && we_n;
	initial clash = 0;
	// data only valid a full access time after select
	always @(negedge ce_n) t_sel = $realtime;
	// polled, so a quick reselect restarts the access time
	always #1 begin
		acc_ok = !ce_n && ($realtime - t_sel >= ACC_NS);
		busy = $realtime < busy_until;
	end
	// address on later falling strobe, data on earlier rising
	always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n && oe_n) cap_a = addr;
	always @(posedge we_n or posedge ce_n) if (we_n != ce_n && oe_n) latch(cap_a, din);
	// unaddressed latch steers the mode
	task automatic latch(input logic [18:0] a, input logic [7:0] d);
		if (d == RST_CODE) autosel = 1'b0;
		else if (d == AS_CODE) autosel = 1'b1;
		else if (d == ERASE_CODE || d == CHIP_CODE) begin
			// one sector per command or all; runs on through deselect
			foreach (mem[k]) if (d == CHIP_CODE || k[18:16] == a[18:16]) mem[k] = 8'hFF;
			busy_until = $realtime + BUSY_NS;
		end
		else mem[a] = d; // no unlock cycles, kept brief
	endtask : latch
	// status, identifier, protection or array byte
	always @(addr or autosel or hv or ce_n or oe_n or we_n or acc_ok or busy) begin
		if (busy) val = STATUS; // status instead of data while erasing
		else if ((autosel || hv) && !addr[6]) case (addr[1:0])
			2'b00: val = MAKER;
			2'b01: val = PART;
			2'b10: val = {7'h00, PROT[addr[18:16]]};
			default: val = 8'hFF;
		endcase
		else val = mem.exists(addr) ? mem[addr] : 8'hFF;
	end
	// floating bus shows inverted garbage, never a held value
	assign dq = (drv && acc_ok) ? val : ~val;
	always @(posedge din_oe or posedge drv) if (din_oe && drv) clash++;
endmodule : fbh_flash_model

// [testbench/fbh_host_test.sv]
/* self-checking bench for the flash host sequencer.
 * assumes the flash model file is compiled first. */
`timescale 1ns/10ps
module fbh_host_test;
	// ****
	// wiring
	// ****
	localparam int CE_C = 24;
	localparam int WP_C = 10;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	logic req_ready, rsp_valid, ce_n, oe_n, we_n, hv_en, pins_oe;
	fbh_pkg::fbh_op_e req_op = fbh_pkg::OP_READ;
	logic [18:0] req_addr = 19'h0_0000, addr_pins;
	logic [7:0] req_wdata = 8'h00, rdata, pins_i, pins_o, q;
	logic [2:0] rsp_sector;
	int clash, bad_count = 0, samples_checked = 0;
	fbh_host #(.CE_CYCLES(CE_C), .WP_CYCLES(WP_C), .RESET_CMD(8'hF0)) fbh_host_inst (
		.CLK(clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_READY(req_ready),
		.REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid),
		.RSP_RDATA(rdata), .RSP_SECTOR(rsp_sector), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n),
		.ID_HV_EN(hv_en), .ADDRESS_PINS(addr_pins), .DATA_PINS_I(pins_i),
		.DATA_PINS_O(pins_o), .DATA_PINS_OE(pins_oe));
	fbh_flash_model fbh_flash_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .hv(hv_en),
		.addr(addr_pins), .din(pins_o), .din_oe(pins_oe), .dq(pins_i), .clash(clash));
	initial forever #2.5 clk = ~clk;
	// ****
	// shared tasks
	// ****
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one request; latency counted in negedges after the taking edge
	task automatic op(input fbh_pkg::fbh_op_e o, input logic [18:0] a, input logic [7:0] d);
		int n;
		logic hv_seen;
		n = 0;
		hv_seen = 1'b0;
		@(negedge clk);
		req_op = o;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		// ready only moves on the rising edge, so judge it on the falling one
		while (req_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		do begin
			@(negedge clk);
			req_valid = 1'b0;
			n++;
			hv_seen |= hv_en;
		end while (rsp_valid !== 1'b1 && n < 300);
		q = rdata;
		check("latency", n, (o == fbh_pkg::OP_WRITE || o == fbh_pkg::OP_RESET) ? WP_C + 3 : CE_C + 2);
		check("id level", hv_seen, o == fbh_pkg::OP_IDREAD);
		check("sector", rsp_sector, a[18:16]);
	endtask : op
	// ****
	// scenarios
	// ****
	task automatic t_idle();
		check("idle pins", {ce_n, oe_n, we_n, pins_oe, hv_en, req_ready}, 6'h39);
	endtask : t_idle
	task automatic t_array();
		op(fbh_pkg::OP_READ, 19'h1_2345, 8'h00);
		check("fresh byte", q, 8'hFF);
		for (int s = 0; s < 8; s++) op(fbh_pkg::OP_WRITE, {s[2:0], 16'hFFFF}, 8'hA0 ^ s[7:0]);
		for (int s = 0; s < 8; s++) begin
			op(fbh_pkg::OP_READ, {s[2:0], 16'hFFFF}, 8'h00);
			check("array byte", q, 8'hA0 ^ s[7:0]);
		end
	endtask : t_array
	task automatic t_autosel();
		op(fbh_pkg::OP_WRITE, 19'h0_0555, 8'h90);
		op(fbh_pkg::OP_READ, 19'h3_0000, 8'h00);
		check("maker", q, 8'h5A);
		op(fbh_pkg::OP_READ, 19'h0_0001, 8'h00);
		check("part", q, 8'h3C);
		for (int s = 0; s < 8; s++) begin
			op(fbh_pkg::OP_READ, {s[2:0], 16'h0002}, 8'h00);
			check("protect", q, {7'h00, 8'h24 >> s} & 8'h01);
		end
		op(fbh_pkg::OP_RESET, 19'h0_0000, 8'h00);
		op(fbh_pkg::OP_READ, 19'h2_FFFF, 8'h00);
		check("after reset", q, 8'hA2);
	endtask : t_autosel
	task automatic t_idread();
		op(fbh_pkg::OP_IDREAD, 19'h0_0001, 8'h00);
		check("hv part", q, 8'h3C);
		op(fbh_pkg::OP_READ, 19'h7_FFFF, 8'h00);
		check("hv gone", q, 8'hA7);
	endtask : t_idread
	task automatic t_erase();
		op(fbh_pkg::OP_WRITE, 19'h3_0000, 8'h30);
		op(fbh_pkg::OP_READ, 19'h3_FFFF, 8'h00);
		check("busy status", q, 8'h4C);
		repeat (80) @(negedge clk);
		op(fbh_pkg::OP_READ, 19'h3_FFFF, 8'h00);
		check("sector erased", q, 8'hFF);
		op(fbh_pkg::OP_READ, 19'h4_FFFF, 8'h00);
		check("sector kept", q, 8'hA4);
		op(fbh_pkg::OP_WRITE, 19'h0_0000, 8'h10);
		repeat (80) @(negedge clk);
		op(fbh_pkg::OP_READ, 19'h4_FFFF, 8'h00);
		check("chip erased", q, 8'hFF);
	endtask : t_erase
	// ****
	// run control
	// ****
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	initial begin
		#40_000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk) resetn = 1'b1;
		t_idle();
		t_array();
		t_autosel();
		t_idread();
		t_erase();
		repeat (3) @(negedge clk);
		t_idle();
		check("contention", clash, 0);
		end_of_test();
	end
endmodule : fbh_host_test
